/* rtl/seq_address_sequencer.sv */
// ************************************************************************
// microprogram address sequencer, top level
// ************************************************************************
// produces the next control store address every clock from a function
// code, a condition and a branch target; pins pass a two-stage synchroniser.
// assumes the control store outside applies the pin drivers from oe.
//
// Contract
// - ten bit address register loaded every edge
// - next address from five sources
// - three bit function code decodes eight functions
// - jump-to-zero clears address, stack untouched
// - increment always adds one, wraps around
// - condition low gives plus one
// - skip with condition high adds two
// - branch with condition high loads target
// - call with condition high pushes plus one, loads target
// - return loads stack top and pops
// - loop push stores current, adds one
// - loop branch always pops, loads if true
// - four entry lifo, pointer marks next write
// - pointer wraps modulo four both ways
// - empty pop reads wrapped entry, undefined
// - disabled outputs float, sequencing continues
`timescale 1ns/10ps
module seq_address_sequencer (
    input  wire logic                        clk_i,               // 25 MHz system clock
    input  wire logic                        rstn_i,              // async reset, active low
    input  wire logic [seq_pkg::FUNC_W-1:0]  seq_func_sel_i,      // function select pins
    input  wire logic                        cond_i,              // condition pin
    input  wire logic [seq_pkg::ADDR_W-1:0]  branch_target_in_i,  // branch target pins
    input  wire logic                        out_en_n_i,          // output enable, active low
    output logic      [seq_pkg::ADDR_W-1:0]  next_addr_out_o,     // address to control store
    output logic                             next_addr_oe_o,      // high while address driven
    output logic      [seq_pkg::PTR_W-1:0]   stack_ptr_o          // stack pointer, observation
);

    // ********************************************************************
    // state and decode
    // ********************************************************************
    seq_pkg::seq_state_t               st_reg;
    seq_pkg::seq_state_t               st_next;
    seq_pkg::pin_in_t                  pins;
    seq_pkg::seq_op_t                  op;
    logic [seq_pkg::ADDR_W-1:0]        plus_one;
    logic [seq_pkg::ADDR_W-1:0]        plus_two;
    logic [seq_pkg::ADDR_W-1:0]        stack_top;
    logic [seq_pkg::ADDR_W-1:0]        push_data;
    logic [seq_pkg::PTR_W-1:0]         stack_ptr;

    // decode one function and condition into a source and stack action;
    // used by the datapath only; the checks below compare f and c directly
    function automatic seq_pkg::seq_op_t decode_op(
        input logic [seq_pkg::FUNC_W-1:0] func,
        input logic                       cond
    );
        seq_pkg::seq_op_t r;
        r.src      = seq_pkg::SRC_PLUS_ONE;
        r.push     = 1'b0;
        r.pop      = 1'b0;
        r.push_one = 1'b0;
        case (func)
            seq_pkg::FUNC_COND_SKIP:
                r.src = cond ? seq_pkg::SRC_PLUS_TWO : seq_pkg::SRC_PLUS_ONE;
            seq_pkg::FUNC_INCREMENT:
                r.src = seq_pkg::SRC_PLUS_ONE;
            seq_pkg::FUNC_LOOP_BRANCH:
            begin
                r.src = cond ? seq_pkg::SRC_STACK : seq_pkg::SRC_PLUS_ONE;
                r.pop = 1'b1;
            end
            seq_pkg::FUNC_RETURN_POP:
            begin
                r.src = seq_pkg::SRC_STACK;
                r.pop = 1'b1;
            end
            seq_pkg::FUNC_COND_CALL:
            begin
                r.src      = cond ? seq_pkg::SRC_BRANCH : seq_pkg::SRC_PLUS_ONE;
                r.push     = cond;
                r.push_one = 1'b1;
            end
            seq_pkg::FUNC_LOOP_PUSH:
            begin
                r.src  = seq_pkg::SRC_PLUS_ONE;
                r.push = 1'b1;
            end
            seq_pkg::FUNC_COND_BRANCH:
                r.src = cond ? seq_pkg::SRC_BRANCH : seq_pkg::SRC_PLUS_ONE;
            default:
                r.src = seq_pkg::SRC_ZERO;
        endcase
        return r;
    endfunction

    // ********************************************************************
    // pin sampling
    // ********************************************************************
    // group the pins into one sample for the synchroniser
    always_comb
    begin
        pins.func     = seq_func_sel_i;
        pins.cond     = cond_i;
        pins.branch   = branch_target_in_i;
        pins.out_en_n = out_en_n_i;
    end

    // ********************************************************************
    // datapath
    // ********************************************************************
    // the adders are ten bits wide so the top address wraps to zero for free
    assign plus_one = st_reg.addr + seq_pkg::ADDR_STEP_ONE;
    assign plus_two = st_reg.addr + seq_pkg::ADDR_STEP_TWO;

    // only the second stage feeds decode; the first is left to settle
    assign op = decode_op(st_reg.sync2.func, st_reg.sync2.cond);

    // a call returns past itself, a loop push returns to itself
    assign push_data = op.push_one ? plus_one : st_reg.addr;

    // five-way address selection and the registered enable
    always_comb
    begin
        st_next       = st_reg;
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        // the enable only steers the pad, never the sequencing
        st_next.oe    = ~st_reg.sync2.out_en_n;
        case (op.src)
            seq_pkg::SRC_BRANCH:   st_next.addr = st_reg.sync2.branch;
            seq_pkg::SRC_PLUS_ONE: st_next.addr = plus_one;
            seq_pkg::SRC_PLUS_TWO: st_next.addr = plus_two;
            seq_pkg::SRC_STACK:    st_next.addr = stack_top;
            default:               st_next.addr = seq_pkg::ADDR_ZERO;
        endcase
    end

    // one register for the whole state; the address loads on every edge.
    // reset gives a known zero start; software should still open with the
    // all-ones function since the part itself promises no power-up value
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg.sync1 <= seq_pkg::PIN_RESET;
            st_reg.sync2 <= seq_pkg::PIN_RESET;
            st_reg.addr  <= seq_pkg::ADDR_ZERO;
            st_reg.oe    <= seq_pkg::OE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ********************************************************************
    // return stack
    // ********************************************************************
    seq_return_stack #(
        .WIDTH (seq_pkg::ADDR_W),
        .DEPTH (seq_pkg::STACK_DEPTH)
    ) u_stack (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .push_i      (op.push),
        .pop_i       (op.pop),
        .push_data_i (push_data),
        .top_o       (stack_top),
        .ptr_o       (stack_ptr)
    );

    // ********************************************************************
    // outputs
    // ********************************************************************
    // the address keeps counting while the pads float
    assign next_addr_out_o = st_reg.addr;
    assign next_addr_oe_o  = st_reg.oe;
    assign stack_ptr_o     = stack_ptr;

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic [seq_pkg::FUNC_W-1:0] f;
    logic                       c;
    assign f = st_reg.sync2.func;
    assign c = st_reg.sync2.cond;

    AST_JUMP_ZERO: assert property (f == seq_pkg::FUNC_JUMP_ZERO |=>
        next_addr_out_o == 10'h000 && $stable(stack_ptr))
        else $error("jump to zero did not clear address or moved stack");

    AST_INCREMENT: assert property (f == seq_pkg::FUNC_INCREMENT |=>
        next_addr_out_o == $past(next_addr_out_o) + 10'h001 && $stable(stack_ptr))
        else $error("increment did not add one");

    AST_COND_LOW: assert property (!c && (f == seq_pkg::FUNC_COND_SKIP
        || f == seq_pkg::FUNC_COND_CALL || f == seq_pkg::FUNC_COND_BRANCH) |=>
        next_addr_out_o == $past(next_addr_out_o) + 10'h001 && $stable(stack_ptr))
        else $error("false condition did not step by one");

    AST_SKIP: assert property (c && f == seq_pkg::FUNC_COND_SKIP |=>
        next_addr_out_o == $past(next_addr_out_o) + 10'h002 && $stable(stack_ptr))
        else $error("skip did not step by two");

    AST_BRANCH: assert property (c && f == seq_pkg::FUNC_COND_BRANCH |=>
        next_addr_out_o == $past(st_reg.sync2.branch) && $stable(stack_ptr))
        else $error("branch did not load target");

    AST_CALL: assert property (c && f == seq_pkg::FUNC_COND_CALL |=>
        next_addr_out_o == $past(st_reg.sync2.branch) && stack_ptr == $past(stack_ptr) + 2'h1
        && stack_top == $past(next_addr_out_o) + 10'h001)
        else $error("call did not push return address and load target");

    AST_RETURN: assert property (f == seq_pkg::FUNC_RETURN_POP |=>
        next_addr_out_o == $past(stack_top) && stack_ptr == $past(stack_ptr) - 2'h1)
        else $error("return did not load stack top and pop");

    AST_LOOP_PUSH: assert property (f == seq_pkg::FUNC_LOOP_PUSH |=>
        stack_top == $past(next_addr_out_o) && stack_ptr == $past(stack_ptr) + 2'h1
        && next_addr_out_o == $past(next_addr_out_o) + 10'h001)
        else $error("loop push stored wrong value");

    AST_LOOP_BRANCH: assert property (f == seq_pkg::FUNC_LOOP_BRANCH |=>
        stack_ptr == $past(stack_ptr) - 2'h1 && next_addr_out_o ==
        ($past(c) ? $past(stack_top) : $past(next_addr_out_o) + 10'h001))
        else $error("loop branch went wrong way");

    AST_PUSH_POP_ROUND: assert property (f == seq_pkg::FUNC_LOOP_PUSH ##1
        f == seq_pkg::FUNC_RETURN_POP |=> next_addr_out_o == $past(next_addr_out_o, 2)
        && stack_ptr == $past(stack_ptr, 2))
        else $error("push then pop did not return pushed address");

    AST_WRAP: assert property (stack_ptr == 2'h3 && f == seq_pkg::FUNC_LOOP_PUSH
        |=> stack_ptr == 2'h0)
        else $error("stack pointer did not wrap");

    AST_OE_PATH: assert property (out_en_n_i |=> ##2 !next_addr_oe_o)
        else $error("outputs not released three edges after disable");

    AST_OE_RUNS: assert property (f == seq_pkg::FUNC_INCREMENT && !next_addr_oe_o
        |=> next_addr_out_o == $past(next_addr_out_o) + 10'h001)
        else $error("sequencing stalled while outputs disabled");

    COV_CALL_RETURN: cover property (c && f == seq_pkg::FUNC_COND_CALL ##[1:8]
        f == seq_pkg::FUNC_RETURN_POP);
    COV_LOOP_TAKEN: cover property (c && f == seq_pkg::FUNC_LOOP_BRANCH);
    COV_FULL_PUSH: cover property (stack_ptr == 2'h3 && f == seq_pkg::FUNC_LOOP_PUSH);
    COV_ADDR_WRAP: cover property (next_addr_out_o == 10'h3ff && f == seq_pkg::FUNC_INCREMENT);

endmodule

/* rtl/seq_pkg.sv */
// ************************************************************************
// shared constants and types of the microprogram address sequencer
// ************************************************************************
// holds widths, function codes, reset values and the carrier structs.
// assumes every user refers to items as seq_pkg::name, nothing imported.
package seq_pkg;

    // ********************************************************************
    // widths and depths
    // ********************************************************************
    localparam int ADDR_W      = 10;  // control store address width
    localparam int STACK_DEPTH = 4;   // return stack entries
    localparam int PTR_W       = 2;   // stack pointer width
    localparam int FUNC_W      = 3;   // function select width

    // ********************************************************************
    // function select codes, most significant bit first
    // ********************************************************************
    localparam logic [FUNC_W-1:0] FUNC_COND_SKIP   = 3'h0;  // cond_skip_func
    localparam logic [FUNC_W-1:0] FUNC_INCREMENT   = 3'h1;  // plain sequential step
    localparam logic [FUNC_W-1:0] FUNC_LOOP_BRANCH = 3'h2;  // loop_branch_func
    localparam logic [FUNC_W-1:0] FUNC_RETURN_POP  = 3'h3;  // return from subroutine
    localparam logic [FUNC_W-1:0] FUNC_COND_CALL   = 3'h4;  // cond_call_func
    localparam logic [FUNC_W-1:0] FUNC_LOOP_PUSH   = 3'h5;  // loop_push_func
    localparam logic [FUNC_W-1:0] FUNC_COND_BRANCH = 3'h6;  // cond_branch_func
    localparam logic [FUNC_W-1:0] FUNC_JUMP_ZERO   = 3'h7;  // jump to address zero

    // ********************************************************************
    // address steps and reset values
    // ********************************************************************
    localparam logic [ADDR_W-1:0] ADDR_STEP_ONE = 10'h001;  // current plus one
    localparam logic [ADDR_W-1:0] ADDR_STEP_TWO = 10'h002;  // current plus two
    localparam logic [ADDR_W-1:0] ADDR_ZERO     = 10'h000;  // jump target and reset value
    localparam logic [PTR_W-1:0]  PTR_RESET     = 2'h0;     // stack pointer after reset
    localparam logic              OE_RESET      = 1'b0;     // outputs released in reset

    // ********************************************************************
    // carrier types
    // ********************************************************************
    // one sample of every input pin
    typedef struct packed {
        logic [FUNC_W-1:0] func;      // function select
        logic              cond;      // condition input
        logic [ADDR_W-1:0] branch;    // branch target
        logic              out_en_n;  // output enable, active low
    } pin_in_t;

    // synchroniser stages come up holding the jump-to-zero function
    localparam pin_in_t PIN_RESET = '{func: 3'h7, cond: 1'b0, branch: 10'h000, out_en_n: 1'b1};

    // source of the next address
    typedef enum logic [2:0] {
        SRC_BRANCH,
        SRC_PLUS_ONE,
        SRC_PLUS_TWO,
        SRC_STACK,
        SRC_ZERO
    } addr_src_t;

    // decoded action of one function
    typedef struct packed {
        addr_src_t src;       // next address source
        logic      push;      // write the stack
        logic      pop;       // read and drop the stack top
        logic      push_one;  // pushed value is current plus one
    } seq_op_t;

    // whole state of the top module
    typedef struct packed {
        pin_in_t           sync1;  // first synchroniser stage
        pin_in_t           sync2;  // second synchroniser stage
        logic [ADDR_W-1:0] addr;   // address register
        logic              oe;     // registered output enable
    } seq_state_t;

endpackage

/* rtl/seq_return_stack.sv */
// ************************************************************************
// four entry lifo return stack with wrapping pointer
// ************************************************************************
// holds the return and loop addresses of the sequencer.
// assumes push and pop are never asserted together by the caller.
`timescale 1ns/10ps
module seq_return_stack #(
    parameter int WIDTH = seq_pkg::ADDR_W,      // entry width
    parameter int DEPTH = seq_pkg::STACK_DEPTH  // number of entries
) (
    input  wire logic                     clk_i,         // system clock
    input  wire logic                     rstn_i,        // async reset, active low
    input  wire logic                     push_i,        // write entry at pointer
    input  wire logic                     pop_i,         // drop most recent entry
    input  wire logic [WIDTH-1:0]         push_data_i,   // value to push
    output logic      [WIDTH-1:0]         top_o,         // most recent entry
    output logic      [$clog2(DEPTH)-1:0] ptr_o          // next entry to write
);

    localparam int PW = $clog2(DEPTH);

    // ********************************************************************
    // elaboration checks
    // ********************************************************************
    // the pointer wraps by plain overflow, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("stack depth must be a power of two of at least two");
    end
    if (WIDTH < 1)
    begin : g_bad_width
        $error("stack width must be at least one");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // entries
        logic [PW-1:0]               ptr;  // next entry to write
    } stack_state_t;

    stack_state_t st_reg;
    stack_state_t st_next;

    // ********************************************************************
    // next state
    // ********************************************************************
    // a push onto a full stack lands on the oldest entry, keeping the newest four
    always_comb
    begin
        st_next = st_reg;
        if (push_i)
        begin
            st_next.mem[st_reg.ptr] = push_data_i;
            st_next.ptr             = st_reg.ptr + PW'(1);
        end
        else if (pop_i)
        begin
            st_next.ptr = st_reg.ptr - PW'(1);
        end
    end

    // entries clear in reset only so simulation shows no unknowns
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // an empty pop reads the last entry through wraparound, content undefined
    assign top_o = st_reg.mem[st_reg.ptr - PW'(1)];
    assign ptr_o = st_reg.ptr;

endmodule

/* tb/ctrl_store_model.sv */
// control store model standing at the sequencer's address pins
// assumes address and enable come straight from the sequencer
`timescale 1ns/10ps
module ctrl_store_model (
    input  wire logic                       clk_i,     // system clock
    input  wire logic [seq_pkg::ADDR_W-1:0] addr_i,    // address pins
    input  wire logic                       addr_oe_i, // address driven
    input  wire logic                       mem_en_i,  // store outputs on
    output seq_pkg::pin_in_t                word_o     // microword fields
);
    logic [seq_pkg::ADDR_W-1:0] last_reg; // last driven address
    logic [seq_pkg::ADDR_W-1:0] rd_addr;  // address the array sees

    // a released address bus drifts, so a different word is read
    always_ff @(posedge clk_i)
        if (addr_oe_i)
            last_reg <= addr_i;
    assign rd_addr = addr_oe_i ? addr_i : ~last_reg;

    // program steps, with one taken branch at 0x006
    always_comb
    begin
        word_o.func     = (rd_addr == 10'h006) ? 3'h6 : 3'h1;
        word_o.cond     = 1'b1;
        word_o.branch   = 10'h040;
        word_o.out_en_n = 1'b1;
        if (!mem_en_i)
            word_o = '1; // pull-ups force the zero jump
    end
endmodule

/* tb/tb.sv */
// self-checking bench of the address sequencer
// assumes seq_pkg and the store model are compiled first
`timescale 1ns/10ps
module tb;
    logic             clk_i;
    logic             rstn_i;
    logic             use_mem;  // pins fed by the store model
    logic             mem_en;   // store outputs enabled
    seq_pkg::pin_in_t pins;     // bench pin values
    seq_pkg::pin_in_t mem_word; // store microword
    seq_pkg::pin_in_t pin_bus;  // what reaches the pins
    seq_pkg::pin_in_t s1;       // reference sync stages
    seq_pkg::pin_in_t s2;
    logic [9:0]       addr_o;
    logic [9:0]       ref_addr;
    logic [9:0]       stk [4];
    logic [1:0]       ptr_o;
    logic [1:0]       ref_ptr;
    logic             oe_o;
    logic             ref_oe;
    int               errors;
    int               n_checks;

    // ****************
    // clock and wiring
    // ****************
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // enable pin stays with the bench; only microword fields come from the store
    assign pin_bus = use_mem ? seq_pkg::pin_in_t'{func: mem_word.func, cond: mem_word.cond,
                                 branch: mem_word.branch, out_en_n: pins.out_en_n} : pins;

    seq_address_sequencer dut (.clk_i(clk_i), .rstn_i(rstn_i), .seq_func_sel_i(pin_bus.func),
        .cond_i(pin_bus.cond), .branch_target_in_i(pin_bus.branch), .out_en_n_i(pin_bus.out_en_n),
        .next_addr_out_o(addr_o), .next_addr_oe_o(oe_o), .stack_ptr_o(ptr_o));
    ctrl_store_model store (.clk_i(clk_i), .addr_i(addr_o), .addr_oe_i(oe_o), .mem_en_i(mem_en),
        .word_o(mem_word));

    // reference sequencer, same two-stage pin latency as the design
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1 <= seq_pkg::PIN_RESET;
            s2 <= seq_pkg::PIN_RESET;
            ref_addr <= '0;
            ref_ptr <= '0;
            ref_oe <= 1'b0;
            stk <= '{default: '0};
        end
        else
        begin
            s1 <= pin_bus;
            s2 <= s1;
            ref_oe <= ~s2.out_en_n;
            case (s2.func)
                3'h0: ref_addr <= ref_addr + (s2.cond ? 10'h002 : 10'h001);
                3'h2:
                begin
                    ref_ptr <= ref_ptr - 2'h1;
                    ref_addr <= s2.cond ? stk[ref_ptr - 2'h1] : ref_addr + 10'h001;
                end
                3'h3:
                begin
                    ref_ptr <= ref_ptr - 2'h1;
                    ref_addr <= stk[ref_ptr - 2'h1];
                end
                3'h4:
                begin
                    stk[ref_ptr] <= s2.cond ? ref_addr + 10'h001 : stk[ref_ptr];
                    ref_ptr <= ref_ptr + {1'b0, s2.cond};
                    ref_addr <= s2.cond ? s2.branch : ref_addr + 10'h001;
                end
                3'h5:
                begin
                    stk[ref_ptr] <= ref_addr;
                    ref_ptr <= ref_ptr + 2'h1;
                    ref_addr <= ref_addr + 10'h001;
                end
                3'h6: ref_addr <= s2.cond ? s2.branch : ref_addr + 10'h001;
                3'h7: ref_addr <= '0;
                default: ref_addr <= ref_addr + 10'h001;
            endcase
        end
    end

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one cycle per step, judged against the reference each cycle
    task automatic op(input logic [2:0] f, input logic c, input logic [9:0] b, input int n);
        repeat (n)
        begin
            pins.func = f;
            pins.cond = c;
            pins.branch = b;
            @(negedge clk_i);
            chk("address", ref_addr, addr_o);
            chk("pointer", {8'h00, ref_ptr}, {8'h00, ptr_o});
            chk("enable", {9'h000, ref_oe}, {9'h000, oe_o});
        end
    endtask

    // leaves address 0 with two zero jumps still in the pipe
    task automatic home();
        op(3'h7, 1'b1, 10'h3ff, 3);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_wrap();
        home();
        op(3'h6, 1'b0, 10'h155, 1);
        op(3'h6, 1'b1, 10'h3fe, 1);
        op(3'h1, 1'b0, 10'h000, 1);
        chk("branch not taken", 10'h001, addr_o);
        op(3'h1, 1'b0, 10'h000, 1);
        chk("branch", 10'h3fe, addr_o);
        op(3'h1, 1'b1, 10'h000, 2);
        chk("wrap", 10'h000, addr_o);
    endtask

    task automatic t_skip();
        home();
        op(3'h0, 1'b0, 10'h000, 1);
        op(3'h0, 1'b1, 10'h000, 1);
        op(3'h1, 1'b0, 10'h000, 1);
        chk("no skip", 10'h001, addr_o);
        op(3'h1, 1'b0, 10'h000, 1);
        chk("skip", 10'h003, addr_o);
    endtask

    task automatic t_call();
        logic [1:0] p;
        home();
        p = ref_ptr;
        op(3'h4, 1'b0, 10'h155, 1);
        op(3'h4, 1'b1, 10'h155, 1);
        op(3'h1, 1'b0, 10'h000, 1);
        chk("call not taken", 10'h001, addr_o);
        op(3'h3, 1'b0, 10'h000, 1);
        chk("call target", 10'h155, addr_o);
        chk("call push", {8'h00, p + 2'h1}, {8'h00, ptr_o});
        op(3'h1, 1'b0, 10'h000, 2);
        chk("return", 10'h002, addr_o);
    endtask

    task automatic t_loop();
        logic [1:0] p;
        home();
        p = ref_ptr;
        op(3'h1, 1'b0, 10'h000, 1);
        op(3'h5, 1'b0, 10'h000, 1);
        op(3'h1, 1'b0, 10'h000, 1);
        op(3'h2, 1'b1, 10'h000, 1);
        chk("loop push", {6'h00, p + 2'h1, 2'h2}, {6'h00, ptr_o, addr_o[1:0]});
        op(3'h5, 1'b0, 10'h000, 1);
        op(3'h2, 1'b0, 10'h000, 1);
        chk("loop taken", 10'h001, addr_o);
        op(3'h1, 1'b0, 10'h000, 2);
        chk("loop exit", {8'h00, p}, {8'h00, ptr_o});
    endtask

    task automatic t_stack();
        logic [9:0] want [4] = '{10'h004, 10'h003, 10'h002, 10'h001};
        logic [1:0] p;
        home();
        p = ref_ptr;
        op(3'h5, 1'b1, 10'h000, 5);
        op(3'h3, 1'b1, 10'h000, 2);
        chk("ptr wrap", {8'h00, p + 2'h1}, {8'h00, ptr_o});
        for (int i = 0; i < 4; i++)
        begin
            op(i < 3 ? 3'h3 : 3'h1, 1'b0, 10'h000, 1);
            chk("lifo", want[i], addr_o);
        end
        op(3'h1, 1'b0, 10'h000, 1);
        chk("empty pop", 10'h004, addr_o);
        op(3'h1, 1'b0, 10'h000, 1);
    endtask

    // outputs released while stepping goes on
    task automatic t_float();
        home();
        pins.out_en_n = 1'b1;
        op(3'h1, 1'b0, 10'h000, 4);
        chk("float step", {8'h00, 2'h2}, {oe_o, 7'h00, addr_o[1:0]});
        pins.out_en_n = 1'b0;
        op(3'h1, 1'b0, 10'h000, 3);
    endtask

    // store disabled: pull-ups hold the zero jump
    task automatic t_ext();
        use_mem = 1'b1;
        op(3'h1, 1'b0, 10'h000, 10);
        mem_en = 1'b0;
        op(3'h1, 1'b0, 10'h000, 3);
        chk("pulled reset", 10'h000, addr_o);
        op(3'h1, 1'b0, 10'h000, 2);
        chk("held zero", 10'h000, addr_o);
        mem_en = 1'b1;
        op(3'h1, 1'b0, 10'h000, 4);
        use_mem = 1'b0;
    endtask

    // ****************
    // main sequence and watchdog
    // ****************
    initial
    begin
        errors = 0;
        n_checks = 0;
        rstn_i = 1'b0;
        use_mem = 1'b0;
        mem_en = 1'b1;
        pins = seq_pkg::PIN_RESET;
        pins.out_en_n = 1'b0;
        repeat (20) @(negedge clk_i);
        chk("reset state", 10'h000, {ptr_o, oe_o, addr_o[6:0]});
        rstn_i = 1'b1;
        t_wrap();
        t_skip();
        t_call();
        t_loop();
        t_stack();
        t_float();
        t_ext();
        summarize();
    end

    // the run needs about 100 cycles
    initial
    begin
        repeat (2000) @(posedge clk_i);
        errors++;
        summarize();
    end
endmodule
